// ===== hdl/arsf_defs.svh
`ifndef ARSF_DEFS_SVH
`define ARSF_DEFS_SVH
// Behaviour
// - only last-result read clears data-ready
// - coincident last-result read: ready only if stored
// - other channel read never blocks ready
// - disabling one channel still stores others
// - status read clears global overrun, set wins
// - stored completion while ready sets global overrun
// - result read never blocks global overrun
// - disabling another channel never blocks channel/global overrun
// - status read clears channel overrun, set wins
// - result or last-result read clears done
// - disabled channel never raises done flag
// - channel read clears only its done

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ARSF_OFS_CHEN    8'h10
`define ARSF_OFS_CHDIS   8'h14
`define ARSF_OFS_CHSTAT  8'h18
`define ARSF_OFS_STATUS  8'h1C
`define ARSF_OFS_LAST    8'h20
`define ARSF_OFS_IMASK   8'h24
`define ARSF_OFS_ISTAT   8'h28
`define ARSF_OFS_RES0    8'h30

// ****************************************************************
// field positions
// ****************************************************************
`define ARSF_ST_DONE_LSB 0
`define ARSF_ST_OVR_LSB  8
`define ARSF_ST_READY    16
`define ARSF_ST_GOVR     17
`define ARSF_LAST_CH_LSB 12
`define ARSF_EV_STORE    0
`define ARSF_EV_CHOVR    1
`define ARSF_EV_GOVR     2

// ****************************************************************
// reset values and answers
// ****************************************************************
`define ARSF_CHEN_RST    8'h00
`define ARSF_IMASK_RST   3'h0
`define ARSF_RESP_OKAY   2'h0
`define ARSF_RESP_SLVERR 2'h2
`endif

// ===== hdl/arsf_pkg.sv
package arsf_pkg;
  // write request taken from the bus, one cycle
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } arsf_wreq_t;
  // read request taken from the bus, one cycle
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } arsf_rreq_t;
  // end of conversion from the converter core
  typedef struct packed {
    logic       done;
    logic [2:0] chan;
    logic [9:0] data;
  } arsf_conv_t;
endpackage : arsf_pkg

// ===== hdl/arsf_axil.sv
`timescale 1ns/10ps
// axi4-lite slave: one write and one read in flight, registered answers
module arsf_axil (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // write channels
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // read channels
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // register side
  output arsf_pkg::arsf_wreq_t    wreq,
  input  wire logic               wr_err,
  output arsf_pkg::arsf_rreq_t    rreq,
  input  wire logic [31:0]        rd_data,
  input  wire logic               rd_err
);
  `include "arsf_defs.svh"

  // ****************************************************************
  // write path
  // ****************************************************************
  // address and data are taken together, none while a response waits
  assign awready = awvalid & wvalid & ~bvalid;
  assign wready  = awready;
  assign wreq    = '{valid: awready, addr: awaddr, data: wdata, strb: wstrb};

  // write response held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `ARSF_RESP_OKAY;
    end else if (awready) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? `ARSF_RESP_SLVERR : `ARSF_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  assign arready = ~rvalid;
  assign rreq    = '{valid: arvalid & ~rvalid, addr: araddr};

  // read data captured at the address edge, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `ARSF_RESP_OKAY;
    end else if (rreq.valid) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_err ? `ARSF_RESP_SLVERR : `ARSF_RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : arsf_axil

// ===== hdl/arsf_irq.sv
`timescale 1ns/10ps
// sticky event bits, write-one-to-clear, masked onto one level output
module arsf_irq #(
  parameter int NEV = 3
) (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // events and software access
  input  wire logic [NEV-1:0] event_in,
  input  wire logic           clr_wr,
  input  wire logic [NEV-1:0] clr_bits,
  input  wire logic           mask_wr,
  input  wire logic [NEV-1:0] mask_bits,
  // state and interrupt
  output logic [NEV-1:0]      status_reg,
  output logic [NEV-1:0]      mask_reg,
  output logic                irq
);
  `include "arsf_defs.svh"

  // sticky status, a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~(clr_wr ? clr_bits : '0)) | event_in;
    end
  end

  // mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= NEV'(`ARSF_IMASK_RST);
    end else if (mask_wr) begin
      mask_reg <= mask_bits;
    end
  end

  assign irq = |(status_reg & mask_reg);
endmodule : arsf_irq

// ===== hdl/arsf_flags.sv
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
// converter result registers and status flags behind an axi4-lite port
module arsf_flags #(
  parameter int NCH = 8,
  parameter int DW  = 10
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write
  input  wire logic [7:0]    s_awaddr,
  input  wire logic          s_awvalid,
  output logic               s_awready,
  input  wire logic [31:0]   s_wdata,
  input  wire logic [3:0]    s_wstrb,
  input  wire logic          s_wvalid,
  output logic               s_wready,
  output logic [1:0]         s_bresp,
  output logic               s_bvalid,
  input  wire logic          s_bready,
  // axi4-lite read
  input  wire logic [7:0]    s_araddr,
  input  wire logic          s_arvalid,
  output logic               s_arready,
  output logic [31:0]        s_rdata,
  output logic [1:0]         s_rresp,
  output logic               s_rvalid,
  input  wire logic          s_rready,
  // converter core
  input  arsf_pkg::arsf_conv_t conv,
  output logic [NCH-1:0]     chan_enable,
  // interrupt
  output logic               irq
);
  `include "arsf_defs.svh"

  // ****************************************************************
  // bus slave
  // ****************************************************************
  arsf_pkg::arsf_wreq_t wreq;      // write taken this cycle
  arsf_pkg::arsf_rreq_t rreq;      // read taken this cycle
  logic [31:0]          rd_data;   // read mux
  logic                 rd_err;    // unmapped read
  logic                 wr_err;    // unmapped write

  arsf_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_awaddr),
    .awvalid (s_awvalid),
    .awready (s_awready),
    .wdata   (s_wdata),
    .wstrb   (s_wstrb),
    .wvalid  (s_wvalid),
    .wready  (s_wready),
    .bresp   (s_bresp),
    .bvalid  (s_bvalid),
    .bready  (s_bready),
    .araddr  (s_araddr),
    .arvalid (s_arvalid),
    .arready (s_arready),
    .rdata   (s_rdata),
    .rresp   (s_rresp),
    .rvalid  (s_rvalid),
    .rready  (s_rready),
    .wreq    (wreq),
    .wr_err  (wr_err),
    .rreq    (rreq),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  logic [NCH-1:0]    chen_reg;    // channel enables
  logic [NCH-1:0]    done_reg;    // per-channel conversion done
  logic [NCH-1:0]    ovr_reg;     // per-channel overrun
  logic              ready_reg;   // data_ready_flag
  logic              govr_reg;    // global_overrun_flag
  logic [DW-1:0]     last_reg;    // last_result_register data
  logic [2:0]        lastch_reg;  // channel of last result
  logic [DW-1:0]     res_reg [NCH]; // channel_result_register array
  logic [2:0]        ev_status;   // interrupt status
  logic [2:0]        ev_mask;     // interrupt mask

  // ****************************************************************
  // decode of bus accesses
  // ****************************************************************
  logic [31:0]    wmask;       // byte-lane mask
  logic [31:0]    wbits;       // written data, lanes applied
  logic [NCH-1:0] en_now;      // enable written this cycle
  logic [NCH-1:0] dis_now;     // disable written this cycle
  logic           st_rd;       // status register read
  logic           last_rd;     // last-result register read
  logic [NCH-1:0] res_rd;      // per-channel result read
  logic           wr_map;      // write hits a writable register
  logic           rd_map;      // read hits a readable register

  assign wmask = {{8{wreq.strb[3]}}, {8{wreq.strb[2]}},
                  {8{wreq.strb[1]}}, {8{wreq.strb[0]}}};
  assign wbits = wreq.data & wmask;

  // write decode
  always_comb begin
    en_now  = '0;
    dis_now = '0;
    wr_map  = 1'b1;
    unique case (wreq.addr)
      `ARSF_OFS_CHEN:  en_now  = wbits[NCH-1:0];
      `ARSF_OFS_CHDIS: dis_now = wbits[NCH-1:0];
      `ARSF_OFS_IMASK: wr_map  = 1'b1;
      `ARSF_OFS_ISTAT: wr_map  = 1'b1;
      default:         wr_map  = 1'b0;
    endcase
    if (!wreq.valid) begin
      en_now  = '0;
      dis_now = '0;
    end
  end
  assign wr_err = ~wr_map;

  // read side effects come from the accepted read address
  assign st_rd   = rreq.valid && (rreq.addr == `ARSF_OFS_STATUS);
  assign last_rd = rreq.valid && (rreq.addr == `ARSF_OFS_LAST);

  // ****************************************************************
  // end of conversion
  // ****************************************************************
  logic [NCH-1:0] en_eff;     // enables, minus channels disabled now
  logic [NCH-1:0] hit;        // channel that completes and is stored
  logic           store;      // a result is stored this cycle
  logic           ovr_event;  // a channel overrun occurs now
  logic           govr_set;   // a new general overrun occurs now

  assign en_eff = chen_reg & ~dis_now;
  always_comb begin
    hit = '0;
    if (conv.done && 32'(conv.chan) < NCH) begin
      hit[conv.chan] = en_eff[conv.chan];
    end
  end
  assign store     = |hit;
  assign ovr_event = |(hit & done_reg);
  assign govr_set  = store & ready_reg;

  // ****************************************************************
  // channel enables
  // ****************************************************************
  // enable and disable writes are set/clear masks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chen_reg <= NCH'(`ARSF_CHEN_RST);
    end else begin
      chen_reg <= (chen_reg | en_now) & ~dis_now;
    end
  end
  assign chan_enable = chen_reg;

  // ****************************************************************
  // per-channel flags and results
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic done_clr; // read clears this channel's done flag
      assign res_rd[gi] = rreq.valid &&
                          (rreq.addr == 8'(`ARSF_OFS_RES0 + 4 * gi));
      // own result read or last-result read naming this channel
      assign done_clr = res_rd[gi] || (last_rd && lastch_reg == 3'(gi));

      // done flag, set wins over a clear
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          done_reg[gi] <= 1'b0;
        end else begin
          done_reg[gi] <= (done_reg[gi] & ~done_clr) | hit[gi];
        end
      end

      // overrun flag, cleared by a status read, a new overrun wins
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ovr_reg[gi] <= 1'b0;
        end else begin
          ovr_reg[gi] <= (ovr_reg[gi] & ~st_rd) | (hit[gi] & done_reg[gi]);
        end
      end

      // result register of this channel
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          res_reg[gi] <= '0;
        end else if (hit[gi]) begin
          res_reg[gi] <= conv.data;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // global flags and last result
  // ****************************************************************
  // data ready: cleared only by the last-result read, store wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (ready_reg & ~last_rd) | store;
    end
  end

  // global overrun: status read clears unless a new one occurs now
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      govr_reg <= 1'b0;
    end else begin
      govr_reg <= (govr_reg & ~st_rd) | govr_set;
    end
  end

  // last result and its channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg   <= '0;
      lastch_reg <= 3'h0;
    end else if (store) begin
      last_reg   <= conv.data;
      lastch_reg <= conv.chan;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  arsf_irq #(.NEV(3)) u_irq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .event_in   ({govr_set, ovr_event, store}),
    .clr_wr     (wreq.valid && wreq.addr == `ARSF_OFS_ISTAT),
    .clr_bits   (wbits[2:0]),
    .mask_wr    (wreq.valid && wreq.addr == `ARSF_OFS_IMASK),
    .mask_bits  (wbits[2:0]),
    .status_reg (ev_status),
    .mask_reg   (ev_mask),
    .irq        (irq)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_map  = 1'b1;
    unique case (rreq.addr)
      `ARSF_OFS_CHSTAT: rd_data[NCH-1:0] = chen_reg;
      `ARSF_OFS_STATUS: begin
        rd_data[`ARSF_ST_DONE_LSB +: NCH] = done_reg;
        rd_data[`ARSF_ST_OVR_LSB +: NCH]  = ovr_reg;
        rd_data[`ARSF_ST_READY]           = ready_reg;
        rd_data[`ARSF_ST_GOVR]            = govr_reg;
      end
      `ARSF_OFS_LAST: begin
        rd_data[DW-1:0]                    = last_reg;
        rd_data[`ARSF_LAST_CH_LSB +: 3]    = lastch_reg;
      end
      `ARSF_OFS_IMASK:  rd_data[2:0] = ev_mask;
      `ARSF_OFS_ISTAT:  rd_data[2:0] = ev_status;
      default: begin
        rd_map = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (res_rd[i]) begin
            rd_data[DW-1:0] = res_reg[i];
            rd_map          = 1'b1;
          end
        end
      end
    endcase
  end
  assign rd_err = ~rd_map;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ready_res_read: assert property (
    ready_reg && |res_rd && !last_rd |=> ready_reg)
    else $error("data ready lost on a channel result read");

  a_ready_no_store: assert property (
    last_rd && conv.done && !store |=> !ready_reg)
    else $error("data ready set without a stored result");

  a_ready_on_store: assert property (
    store |=> ready_reg && last_reg == $past(conv.data))
    else $error("stored result did not raise data ready");

  a_disable_store: assert property (
    |dis_now && store |=> ready_reg && lastch_reg == $past(conv.chan))
    else $error("result lost while another channel was disabled");

  a_govr_clear: assert property (
    st_rd && !govr_set |=> !govr_reg)
    else $error("status read did not clear global overrun");

  a_govr_set: assert property (
    conv.done && store && ready_reg |=> govr_reg)
    else $error("global overrun missed");

  a_govr_res_read: assert property (
    |res_rd && store && |(hit & done_reg) && ready_reg |=> govr_reg)
    else $error("global overrun missed on result read");

  a_ovr_disable: assert property (
    |dis_now && |(hit & done_reg) && ready_reg
    |=> govr_reg && ovr_reg[$past(conv.chan)])
    else $error("overrun flags missed on disable");

  a_ovr_clear: assert property (
    st_rd && !ovr_event |=> ovr_reg == '0)
    else $error("status read did not clear channel overrun");

  a_done_last_clr: assert property (
    last_rd && !store |=> !done_reg[$past(lastch_reg)])
    else $error("last-result read did not clear done");

  a_done_disabled: assert property (
    conv.done && !store && !done_reg[conv.chan] |=> !done_reg[$past(conv.chan)])
    else $error("disabled channel raised done");

  a_done_other: assert property (
    |res_rd && store && !res_rd[conv.chan] |=> done_reg[$past(conv.chan)])
    else $error("read cleared another channel's done flag");

  a_done_overrun: assert property (
    store && done_reg[conv.chan] |=> done_reg[$past(conv.chan)] ##0
    ovr_reg[$past(conv.chan)])
    else $error("overrun not raised on repeated completion");
endmodule : arsf_flags

// ===== verif/arsf_conv_model.sv
`timescale 1ns/10ps
// converter core stand-in: one end-of-conversion pulse per request
module arsf_conv_model (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // request from the bench
  input  wire logic            go,
  input  wire logic [2:0]      ch,
  // end of conversion towards the flags block
  output arsf_pkg::arsf_conv_t conv
);
  // done pulses for one cycle; idle lines invert so a stale value never passes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv <= '0;
    end else if (go) begin
      conv <= {1'b1, ch, 7'h50, ch};
    end else begin
      conv <= {1'b0, ~conv.chan, ~conv.data};
    end
  end
endmodule : arsf_conv_model

// ===== verif/arsf_flags_bench.sv
`timescale 1ns/10ps
`include "arsf_defs.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
  $display("FAIL %s exp %h got %h", nm, e, s); errors++; end end

module arsf_flags_bench;
  // ****************
  // signals
  // ****************
  logic                 aclk    = 1'b0;  // 50 ns clock
  logic                 aresetn = 1'b0;  // held low for 20 cycles
  logic [7:0]           awaddr  = 8'h00;
  logic                 awvalid = 1'b0;
  logic                 awready;
  logic [31:0]          wdata   = 32'h0;
  logic                 wvalid  = 1'b0;
  logic                 wready;
  logic [1:0]           bresp;
  logic                 bvalid;
  logic                 bready  = 1'b0;
  logic [7:0]           araddr  = 8'h00;
  logic                 arvalid = 1'b0;
  logic                 arready;
  logic [31:0]          rdata;
  logic [1:0]           rresp;
  logic                 rvalid;
  logic                 rready  = 1'b0;
  logic                 go      = 1'b0;  // ask the core model for a completion
  logic [2:0]           gch     = 3'h0;  // channel of that completion
  arsf_pkg::arsf_conv_t conv;
  logic [7:0]           chan_enable;
  logic                 irq;
  int                   errors  = 0;
  int                   n_tests = 0;
  localparam logic [1:0] OK = `ARSF_RESP_OKAY;
  localparam logic [1:0] ER = `ARSF_RESP_SLVERR;

  // free-running clock
  always #25 aclk = ~aclk;

  // ****************
  // instances
  // ****************
  arsf_flags dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .conv(conv), .chan_enable(chan_enable), .irq(irq)
  );
  arsf_conv_model core (.aclk(aclk), .aresetn(aresetn), .go(go), .ch(gch), .conv(conv));

  // ****************
  // tasks
  // ****************
  // expected last-result word of a channel
  function automatic logic [31:0] lastv(input logic [2:0] c);
    return {17'h0, c, 2'h0, 7'h50, c};
  endfunction : lastv

  // closing report, used by the main sequence and by every timeout
  task automatic give_verdict;
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // ec bit 3 set: the core completes channel ec[2:0] at the edge taking the request
  task automatic pre(input logic [3:0] ec);
    @(posedge aclk);
    go  <= ec[3];
    gch <= ec[2:0];
    @(posedge aclk);
    go  <= 1'b0;
  endtask : pre

  // one axi4-lite read, data and response compared
  task automatic rd(input logic [7:0] a, input logic [3:0] ec, input logic [31:0] e,
                    input logic [1:0] er);
    int i;
    pre(ec);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) break;
    end
    if (arready !== 1'b1) begin errors++; give_verdict; end
    arvalid <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
    end
    if (rvalid !== 1'b1) begin errors++; give_verdict; end
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
  endtask : rd

  // one axi4-lite write, response compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] ec,
                    input logic [1:0] er);
    int i;
    pre(ec);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (awready === 1'b1 && wready === 1'b1) break;
    end
    if (awready !== 1'b1) begin errors++; give_verdict; end
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
    end
    if (bvalid !== 1'b1) begin errors++; give_verdict; end
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
  endtask : wr

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and refused accesses
    rd(`ARSF_OFS_CHSTAT, 4'h0, 32'h0, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0, OK);
    rd(`ARSF_OFS_IMASK, 4'h0, 32'h0, OK);
    rd(`ARSF_OFS_ISTAT, 4'h0, 32'h0, OK);
    rd(8'h04, 4'h0, 32'h0, ER);
    rd(`ARSF_OFS_CHEN, 4'h0, 32'h0, ER);
    wr(`ARSF_OFS_CHEN, 32'h0F, 4'h0, OK);
    rd(`ARSF_OFS_CHSTAT, 4'h0, 32'h0F, OK);
    `CHK("chan_enable", 8'h0F, chan_enable)
    // plain completion, then channel read and last-result read
    pre(4'h9);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0001_0002, OK);
    rd(`ARSF_OFS_RES0 + 8'h04, 4'h0, 32'h281, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0001_0000, OK);
    rd(`ARSF_OFS_LAST, 4'h0, lastv(3'h1), OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0, OK);
    // channel 1 read while channel 2 completes again
    pre(4'hA);
    rd(`ARSF_OFS_RES0 + 8'h04, 4'hA, 32'h281, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0003_0404, OK);
    // status reads landing on completions
    rd(`ARSF_OFS_STATUS, 4'hA, 32'h0001_0004, OK);
    rd(`ARSF_OFS_LAST, 4'h0, lastv(3'h2), OK);
    rd(`ARSF_OFS_STATUS, 4'hA, 32'h0002_0400, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0001_0004, OK);
    // last-result reads landing on disabled and enabled completions
    rd(`ARSF_OFS_LAST, 4'hD, lastv(3'h2), OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0, OK);
    rd(`ARSF_OFS_LAST, 4'h9, lastv(3'h2), OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0001_0002, OK);
    rd(`ARSF_OFS_LAST, 4'h0, lastv(3'h1), OK);
    // channel read on a repeated completion while data ready is low
    pre(4'hA);
    pre(4'h9);
    rd(`ARSF_OFS_LAST, 4'h0, lastv(3'h1), OK);
    rd(`ARSF_OFS_RES0, 4'hA, 32'h0, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0003_0404, OK);
    rd(`ARSF_OFS_LAST, 4'h0, lastv(3'h2), OK);
    // disables landing on completions of another channel
    wr(`ARSF_OFS_CHDIS, 32'h08, 4'h9, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0001_0002, OK);
    wr(`ARSF_OFS_CHDIS, 32'h01, 4'h9, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0003_0202, OK);
    rd(`ARSF_OFS_CHSTAT, 4'h0, 32'h06, OK);
    `CHK("chan_enable", 8'h06, chan_enable)
    rd(`ARSF_OFS_RES0 + 8'h04, 4'hB, 32'h281, OK);
    rd(`ARSF_OFS_STATUS, 4'h0, 32'h0001_0000, OK);
    rd(`ARSF_OFS_LAST, 4'h0, lastv(3'h1), OK);
    // interrupt: raise, mask, clear
    `CHK("irq", 1'b0, irq)
    rd(`ARSF_OFS_ISTAT, 4'h0, 32'h7, OK);
    wr(`ARSF_OFS_IMASK, 32'h1, 4'h0, OK);
    `CHK("irq", 1'b1, irq)
    wr(`ARSF_OFS_ISTAT, 32'h1, 4'h0, OK);
    `CHK("irq", 1'b0, irq)
    rd(`ARSF_OFS_ISTAT, 4'h0, 32'h6, OK);
    wr(`ARSF_OFS_IMASK, 32'h6, 4'h0, OK);
    `CHK("irq", 1'b1, irq)
    rd(`ARSF_OFS_IMASK, 4'h0, 32'h6, OK);
    wr(`ARSF_OFS_ISTAT, 32'h6, 4'h0, OK);
    `CHK("irq", 1'b0, irq)
    rd(`ARSF_OFS_ISTAT, 4'h0, 32'h0, OK);
    // writes to unmapped and read-only places
    wr(8'h04, 32'h0, 4'h0, ER);
    wr(`ARSF_OFS_STATUS, 32'h0, 4'h0, ER);
    give_verdict;
  end
endmodule : arsf_flags_bench
